//--- hw/passive_serial_config_slave.v
// Device-side passive serial configuration loader
//
// Summary of operation
// - In user mode request, status and load-complete lines all sit high.
// - Host pulling request low abandons user mode and restarts loading.
// - Status line is driven low throughout the power-on reset delay.
// - Load-complete stays low from power-up and throughout loading.
// - Load-complete is released only after all data is received.
// - Two serial clock falling edges after load-complete start user mode.
// - Serial data pin becomes user I/O per the dual-purpose option.
// - Once init-done option is loaded, init-done is low until init ends.
`timescale 1ns/10ps
`include "ps_cfg_map.vh"
module passive_serial_config_slave #(
  parameter POR_CYCLES = `POR_DELAY_CYC,
  parameter [31:0] CFG_BITS = `CFG_BITS_DEFAULT
)(
  // Clock, reset, enable
  input wire sys_clk_i,
  input wire resetn_i,
  input wire clk_en_i,
  // Configuration pins from the host
  input wire config_request_n_i,
  input wire serial_cfg_clock_i,
  input wire serial_cfg_bit_i,
  // Open-drain status line
  input wire cfg_state_line_n_i,
  output reg cfg_state_line_n_o,
  output reg cfg_state_line_n_oe_o,
  // Open-drain load-complete line
  output reg load_complete_o,
  output reg load_complete_oe_o,
  // Init-done line, open drain
  output reg init_done_o,
  output reg init_done_oe_o,
  // Dual-purpose data pin in user mode
  input wire user_pin_keep_i,
  input wire user_pin_out_i,
  input wire user_pin_oe_i,
  output reg user_pin_o,
  output reg user_pin_oe_o,
  // Loaded configuration words towards the fabric
  output reg cfg_word_valid_o,
  input wire cfg_word_ready_i,
  output reg [`CFG_WORD_W-1:0] cfg_word_o,
  output reg user_mode_o
);
  // One-hot states: reset delay, held by request, shifting the stream,
  // waiting for the two closing falls, then user mode
  localparam [4:0] ST_POR = 5'h01;
  localparam [4:0] ST_RESET = 5'h02;
  localparam [4:0] ST_LOAD = 5'h04;
  localparam [4:0] ST_INIT = 5'h08;
  localparam [4:0] ST_USER = 5'h10;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  // Synchroniser stages for the host pins
  reg [1:0] req_sync_r;
  reg [2:0] clk_sync_r;
  reg [1:0] dat_sync_r;
  reg [1:0] st_sync_r;
  // Counters and the input shifter
  reg [31:0] por_cnt_r;
  reg [31:0] bit_cnt_r;
  reg [2:0] shift_cnt_r;
  reg [`CFG_WORD_W-1:0] shift_r;
  reg word_valid_r;
  reg [1:0] fall_cnt_r;
  reg init_opt_r;
  reg fall_armed_r;
  // Internal nets
  wire req_n;
  wire st_line;
  wire clk_rise;
  wire clk_fall;
  wire data_bit;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`CFG_WORD_W-1:0] fifo_out_data;
  wire fifo_flush;
  wire all_bits;
  wire fifo_take;

  // Two-stage synchronisers, third stage for edge finding
  // Reset values match the idle pin levels, so no false edge follows reset
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      req_sync_r <= 2'h3;
      clk_sync_r <= 3'h0;
      dat_sync_r <= 2'h0;
    end
    else if (clk_en_i)
    begin
      req_sync_r <= {req_sync_r[0], config_request_n_i};
      clk_sync_r <= {clk_sync_r[1:0], serial_cfg_clock_i};
      dat_sync_r <= {dat_sync_r[0], serial_cfg_bit_i};
    end
  end

  // Wired status level, seen low while the device itself pulls it
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st_sync_r <= 2'h0;
    else if (clk_en_i)
      st_sync_r <= {st_sync_r[0], cfg_state_line_n_i};
  end

  // Edge between the second and third serial clock stages
  function edge_seen;
    input [1:0] pair;
    input rising;
    begin
      if (rising)
        edge_seen = pair[0] & ~pair[1];
      else
        edge_seen = ~pair[0] & pair[1];
    end
  endfunction

  // Synchronised levels and serial clock edges
  assign req_n = req_sync_r[1];
  assign st_line = st_sync_r[1];
  assign data_bit = dat_sync_r[1];
  assign clk_rise = edge_seen(clk_sync_r[2:1], 1'b1);
  assign clk_fall = edge_seen(clk_sync_r[2:1], 1'b0);
  assign all_bits = (bit_cnt_r == CFG_BITS);
  assign fifo_flush = state_r[2] == 1'b0 && state_r[3] == 1'b0;
  assign fifo_take = fifo_out_valid & (~cfg_word_valid_o | cfg_word_ready_i);

  // Next-state decode
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_POR:
        if (por_cnt_r >= POR_CYCLES - 1)
          state_nxt = ST_RESET;
      ST_RESET:
        if (req_n && st_line)
          state_nxt = ST_LOAD;
      ST_LOAD:
        if (!req_n)
          state_nxt = ST_RESET;
        else if (all_bits && !word_valid_r)
          state_nxt = ST_INIT;
      ST_INIT:
        if (!req_n)
          state_nxt = ST_RESET;
        // Stay until the last byte has left the output register too
        else if (fall_cnt_r == `INIT_FALL_EDGES && !fifo_out_valid &&
                 !cfg_word_valid_o)
          state_nxt = ST_USER;
      ST_USER:
        if (!req_n)
          state_nxt = ST_RESET;
      default:
        state_nxt = ST_POR;
    endcase
  end

  // State, counters and bit capture
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r <= ST_POR;
      por_cnt_r <= 32'h0;
      bit_cnt_r <= 32'h0;
      shift_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      word_valid_r <= 1'b0;
      fall_cnt_r <= 2'h0;
      init_opt_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_r <= state_nxt;
      if (state_r == ST_POR)
        por_cnt_r <= por_cnt_r + 32'h1;
      if (word_valid_r && fifo_in_ready)
        word_valid_r <= 1'b0;
      // A rise met while the last byte still waits for the buffer is
      // dropped, so the fabric must keep the buffer drained
      if (state_r != ST_LOAD)
      begin
        bit_cnt_r <= 32'h0;
        shift_cnt_r <= 3'h0;
        word_valid_r <= 1'b0;
      end
      else if (clk_rise && !all_bits && !word_valid_r)
      begin
        shift_r <= {data_bit, shift_r[7:1]};
        bit_cnt_r <= bit_cnt_r + 32'h1;
        shift_cnt_r <= shift_cnt_r + 3'h1;
        if (shift_cnt_r == 3'h7)
        begin
          word_valid_r <= 1'b1;
          if (bit_cnt_r == 32'h7)
            init_opt_r <= shift_r[`INIT_DONE_OPT_BIT + 1];
        end
      end
      if (state_r == ST_RESET)
        init_opt_r <= 1'b0;
      if (state_r != ST_INIT)
        fall_cnt_r <= 2'h0;
      else if (clk_fall && fall_armed_r && fall_cnt_r != `INIT_FALL_EDGES)
        fall_cnt_r <= fall_cnt_r + 2'h1;
    end
  end

  // Arm the fall counter on a rise seen during initialization, so the
  // trailing fall of the last data bit is never taken as one of the two
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      fall_armed_r <= 1'b0;
    else if (clk_en_i)
    begin
      if (state_r != ST_INIT)
        fall_armed_r <= 1'b0;
      else if (clk_rise)
        fall_armed_r <= 1'b1;
      else if (clk_fall)
        fall_armed_r <= 1'b0;
    end
  end

  // Output pins and fabric side, all registered
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg_state_line_n_o <= 1'b0;
      cfg_state_line_n_oe_o <= 1'b1;
      load_complete_o <= 1'b0;
      load_complete_oe_o <= 1'b1;
      init_done_o <= 1'b0;
      init_done_oe_o <= 1'b0;
      user_pin_o <= 1'b0;
      user_pin_oe_o <= 1'b0;
      cfg_word_valid_o <= 1'b0;
      cfg_word_o <= 8'h00;
      user_mode_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cfg_state_line_n_o <= 1'b0;
      // Status low in reset-delay and while request held low
      cfg_state_line_n_oe_o <= state_nxt[0] | (state_nxt[1] & ~req_n);
      // Load-complete low until every bit is in
      load_complete_o <= 1'b0;
      load_complete_oe_o <= state_nxt[0] | state_nxt[1] | state_nxt[2];
      // Released lines float high in user mode
      init_done_o <= 1'b0;
      init_done_oe_o <= init_opt_r & ~state_nxt[4];
      user_mode_o <= state_nxt[4];
      // Data pin becomes user I/O after loading
      if (state_nxt[4] && !user_pin_keep_i)
      begin
        user_pin_o <= user_pin_out_i;
        user_pin_oe_o <= user_pin_oe_i;
      end
      else
      begin
        user_pin_o <= 1'b0;
        user_pin_oe_o <= 1'b0;
      end
      // Output register for the fabric, emptied outside loading and initialization
      if (fifo_flush)
        cfg_word_valid_o <= 1'b0;
      else if (fifo_take)
      begin
        cfg_word_valid_o <= 1'b1;
        cfg_word_o <= fifo_out_data;
      end
      else if (cfg_word_ready_i)
        cfg_word_valid_o <= 1'b0;
    end
  end

  // Word buffer between shifter and fabric
  // Four words absorb short fabric stalls while the host keeps clocking
  cfg_word_fifo #(
    .WIDTH(`CFG_WORD_W),
    .DEPTH(`CFG_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .flush_i(fifo_flush),
    .in_valid_i(word_valid_r),
    .in_ready_o(fifo_in_ready),
    .in_data_i(shift_r),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_take),
    .out_data_o(fifo_out_data)
  );
endmodule // passive_serial_config_slave

//--- hw/ps_cfg_map.vh
// Constants for the passive serial configuration slave
`ifndef PS_CFG_MAP_VH
`define PS_CFG_MAP_VH
// Power-on reset delay in microseconds and derived cycles at 25 MHz
`define POR_DELAY_US 268
`define SYS_CLK_MHZ 25
`define POR_DELAY_CYC (`POR_DELAY_US * `SYS_CLK_MHZ)
// Bitstream length in bits (default, parameter of the top)
`define CFG_BITS_DEFAULT 32'd64
// Falling edges needed after load complete to enter user mode
`define INIT_FALL_EDGES 2'd2
// Init-done enable option bit position within the first loaded byte
`define INIT_DONE_OPT_BIT 0
// Width of a stream word and depth of the buffer
`define CFG_WORD_W 8
`define CFG_FIFO_DEPTH 4
`endif

//--- hw/cfg_word_fifo.v
// Small flip-flop FIFO for configuration words
`timescale 1ns/10ps
module cfg_word_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4
)(
  // Clock and reset
  input wire sys_clk_i,
  input wire resetn_i,
  input wire clk_en_i,
  input wire flush_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [1:0] wr_ptr_r;
  reg [1:0] rd_ptr_r;
  reg [2:0] count_r;
  wire do_wr;
  wire do_rd;
  integer i;

  // Handshake terms
  assign in_ready_o = (count_r != DEPTH[2:0]);
  assign out_valid_o = (count_r != 3'h0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign do_wr = in_valid_i & in_ready_o;
  assign do_rd = out_valid_o & out_ready_i;

  // Storage and pointers
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      count_r <= 3'h0;
      for (i = 0; i < DEPTH; i = i + 1)
        mem_r[i] <= {WIDTH{1'b0}};
    end
    else if (clk_en_i)
    begin
      if (flush_i)
      begin
        wr_ptr_r <= 2'h0;
        rd_ptr_r <= 2'h0;
        count_r <= 3'h0;
      end
      else
      begin
        if (do_wr)
        begin
          mem_r[wr_ptr_r] <= in_data_i;
          wr_ptr_r <= wr_ptr_r + 2'h1;
        end
        if (do_rd)
          rd_ptr_r <= rd_ptr_r + 2'h1;
        if (do_wr && !do_rd)
          count_r <= count_r + 3'h1;
        else if (do_rd && !do_wr)
          count_r <= count_r - 3'h1;
      end
    end
  end
endmodule // cfg_word_fifo

//--- verification/ps_cfg_checker_assertions.sv
// Port assertions for the passive serial slave
`timescale 1ns/10ps
module ps_cfg_checker #(parameter POR_CYCLES = 20, CFG_BITS = 64) (
  // Clock and inputs
  input wire sys_clk_i,
  input wire resetn_i,
  input wire config_request_n_i,
  input wire serial_cfg_clock_i,
  // Outputs
  input wire cfg_state_line_n_oe_o,
  input wire load_complete_oe_o,
  input wire init_done_oe_o,
  input wire user_pin_oe_o,
  input wire user_mode_o
);
  reg [1:0] sck_r;
  reg [31:0] por_r, rise_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Cycles since reset, serial clock rises since the request
  always @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
      {sck_r, por_r, rise_r} <= 66'h0;
    else
    begin
      sck_r <= {sck_r[0], serial_cfg_clock_i};
      por_r <= por_r + (por_r < POR_CYCLES);
      rise_r <= config_request_n_i ? rise_r + (sck_r == 2'h1) : 32'h0;
    end
  a_user_lines_high: assert property (user_mode_o |->
    !cfg_state_line_n_oe_o && !load_complete_oe_o) else $error("line low");
  a_user_mode_holds: assert property (user_mode_o && config_request_n_i
    |=> user_mode_o) else $error("user mode lost");
  a_request_abandons: assert property (!config_request_n_i [*3] |->
    ##[0:6] !user_mode_o) else $error("user mode kept");
  a_por_status_low: assert property (por_r < POR_CYCLES |->
    cfg_state_line_n_oe_o) else $error("status released early");
  a_done_low_loading: assert property (config_request_n_i &&
    rise_r < CFG_BITS |-> load_complete_oe_o) else $error("done early");
  a_done_after_data: assert property ($fell(load_complete_oe_o) |->
    rise_r >= CFG_BITS) else $error("done before data");
  a_user_after_done: assert property ($rose(user_mode_o) |->
    !$past(load_complete_oe_o, 6)) else $error("user mode too early");
  a_pin_user_only: assert property (user_pin_oe_o |-> user_mode_o ||
    $past(user_mode_o)) else $error("pin driven outside user mode");
  a_init_off_user: assert property (user_mode_o |->
    !init_done_oe_o) else $error("init line low in user mode");
  // Main scenarios reached
  c_done: cover property ($fell(load_complete_oe_o));
  c_user: cover property ($rose(user_mode_o));
  c_reconf: cover property ($fell(user_mode_o));
endmodule // ps_cfg_checker
bind passive_serial_config_slave ps_cfg_checker #(.POR_CYCLES(POR_CYCLES),
  .CFG_BITS(CFG_BITS)) i_chk (.sys_clk_i, .resetn_i, .config_request_n_i,
  .serial_cfg_clock_i, .cfg_state_line_n_oe_o, .load_complete_oe_o,
  .init_done_oe_o, .user_pin_oe_o, .user_mode_o);

//--- verification/host_model.sv
// Host model driving the serial configuration pins
`timescale 1ns/10ps
module host_model (
  // Pins towards the device
  output reg req_n_o = 1'b1,
  output reg sck_o = 1'b0,
  output reg sdat_o = 1'b0
);
  // Bit 0 first, data changed while the clock is low, then inverted at the end
  task send_bits(input [7:0] b, input integer n);
    integer i;
    begin
      #13;
      for (i = 0; i < n; i = i + 1)
      begin
        sdat_o = b[i];
        #160 sck_o = 1'b1;
        #160 sck_o = 1'b0;
      end
      sdat_o = ~sdat_o;
    end
  endtask
  // Request pulse of the given length in ns
  task request(input integer len);
    req_n_o = 1'b0;
    #len req_n_o = 1'b1;
  endtask
endmodule // host_model

//--- verification/testbench.sv
// Self-checking bench for the passive serial slave
`timescale 1ns/10ps
module testbench;
  reg sys_clk_i = 1'b0, resetn_i = 1'b0, rdy = 1'b0, poe = 1'b0, keep = 1'b0;
  wire rq, sck, sd, st, lc, idn, upo, um, wv, upd;
  wire [7:0] wd;
  reg [7:0] got [0:15];
  integer mismatches = 0, n_checks = 0, n_got = 0, k;
  // Clock and host
  always #20 sys_clk_i = ~sys_clk_i;
  host_model i_host (.req_n_o(rq), .sck_o(sck), .sdat_o(sd));
  // Device with a short reset delay, status line pulled up
  passive_serial_config_slave #(.POR_CYCLES(20)) i_dut (.sys_clk_i,
    .resetn_i, .clk_en_i(1'b1), .config_request_n_i(rq),
    .serial_cfg_clock_i(sck), .serial_cfg_bit_i(sd),
    .cfg_state_line_n_i(!st), .cfg_state_line_n_o(),
    .cfg_state_line_n_oe_o(st), .load_complete_o(),
    .load_complete_oe_o(lc), .init_done_o(), .init_done_oe_o(idn),
    .user_pin_keep_i(keep), .user_pin_out_i(1'b1), .user_pin_oe_i(poe),
    .user_pin_o(upd), .user_pin_oe_o(upo), .cfg_word_valid_o(wv),
    .cfg_word_ready_i(rdy), .cfg_word_o(wd), .user_mode_o(um));
  // Collect accepted words
  always @(posedge sys_clk_i)
    if (wv && rdy)
    begin
      got[n_got] <= wd;
      n_got <= n_got + 1;
    end
  // Compare and count
  task check(input [31:0] seen, input [31:0] want);
    n_checks = n_checks + 1;
    mismatches = mismatches + (seen !== want);
    if (seen !== want)
      $display("mismatch at %0t seen %h want %h", $time, seen, want);
  endtask
  // Lines held low through the reset delay
  task t_power_up;
    @(negedge sys_clk_i);
    check(st, 1);
    check(lc, 1);
    repeat (30) @(negedge sys_clk_i);
    check(st, 0);
    $display("power-up test done");
  endtask
  // Whole stream, release after the last bit, then two falls
  task t_load;
    for (k = 0; k < 8; k = k + 1)
      i_host.send_bits(8'h13 + k * 8'h25, 8);
    repeat (10) @(negedge sys_clk_i);
    check({lc, idn, um}, 3'h2);
    check(n_got, 8);
    for (k = 0; k < 8; k = k + 1)
      check(got[k], (8'h13 + k * 8'h25) & 32'hFF);
    i_host.send_bits(8'h00, 1);
    repeat (10) @(negedge sys_clk_i);
    check(um, 0);
    i_host.send_bits(8'h00, 1);
    for (k = 0; k < 60 && um !== 1'b1; k = k + 1)
      @(negedge sys_clk_i);
    check({um, st, lc, idn, upo, upd}, 6'h23);
    @(posedge sys_clk_i) keep <= 1'b1;
    repeat (2) @(negedge sys_clk_i);
    check({um, upo, upd}, 3'h4);
    @(posedge sys_clk_i) keep <= 1'b0;
    @(negedge sys_clk_i);
    $display("load test done");
  endtask
  // Request low leaves user mode and restarts
  task t_reconf;
    i_host.request(200);
    repeat (10) @(negedge sys_clk_i);
    check({um, lc, upo, st}, 4'h4);
    i_host.send_bits(8'h12, 8);
    repeat (10) @(negedge sys_clk_i);
    check({lc, idn, um}, 3'h4);
    check(got[8], 8'h12);
    $display("reconfig test done");
  endtask
  // Verdict
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  // Reset, then the tests
  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rdy <= 1'b1;
    poe <= 1'b1;
    t_power_up;
    t_load;
    t_reconf;
    tally_and_finish;
  end
endmodule // testbench
